// >>> core/vipn_pick.sv
/*
 * combinational priority search over active sources, blocking levels
 * at or below any in-service bit.
 * assumes levels are packed three bits per source.
 */
`timescale 1ns/1ns
module vipn_pick #(
	parameter int unsigned nsrc = 22
) (
	input wire logic [nsrc-1:0] active, // raw and enable
	input wire logic [3*nsrc-1:0] lvls, // per-source level
	input wire logic use_prio, // levels honoured
	input wire logic [7:0] stack, // in-service bits
	output vipn_pkg::vipn_pick_t pick // winner
);
	import vipn_pkg::*;
	logic [2:0] eff;
	logic allow;
	// level 0 wins; lowest index wins a tie
	always_comb begin
		pick = '0;
		eff = 3'h0;
		allow = 1'b0;
		for (int i = nsrc - 1; i >= 0; i--) begin
			eff = use_prio ? lvls[3*i +: 3] : 3'h0; // RQ10
			allow = 1'b1;
			for (int b = 0; b < 8; b++)
				if (stack[b] && eff >= 3'(b))
					allow = 1'b0; // RQ13 RQ20
			if (active[i] && allow &&
				(!pick.found || eff <= pick.lvl)) begin // RQ19
				pick.found = 1'b1;
				pick.src = 5'(i);
				pick.lvl = eff;
			end
		end
	end
endmodule : vipn_pick

// >>> core/vipn_stack.sv
/*
 * eight-level in-service stack: pushes a level on a vector read,
 * pops the lowest set bit on each software write.
 * assumes push and pop are one-cycle pulses from the register slave.
 */
`timescale 1ns/1ns
module vipn_stack #(
	parameter int unsigned levels = 8
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, low
	input wire logic push, // vector read pulse
	input wire logic [2:0] push_lvl, // level of the serviced source
	input wire logic pop, // software write pulse
	output logic [levels-1:0] stack // in-service bits
);
	import vipn_pkg::*;
	logic [levels-1:0] next_stack;
	logic [levels-1:0] low_bit;
	// isolate lowest set bit, push wins over that clear
	always_comb begin
		low_bit = stack & (~stack + 1'b1); // RQ14
		next_stack = stack;
		if (pop)
			next_stack = next_stack & ~low_bit; // RQ14
		if (push)
			next_stack[push_lvl] = 1'b1; // RQ12
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stack <= '0;
		else
			stack <= next_stack;
	end
endmodule : vipn_stack

// >>> core/vipn_top.sv
/*
 * priority and nesting section of a vectored interrupt controller:
 * priority registers, nesting control, in-service stacks, vectors and
 * request lines to the core, reached over apb.
 * assumes raw requests are synchronous levels held until serviced.
 */
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
module vipn_top #(
	parameter int unsigned nsrc = vipn_pkg::vipn_nsrc
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [31:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [nsrc-1:0] normal_raw_request, // normal sources
	input wire logic [nsrc-1:0] fast_raw_request, // fast sources
	output logic normal_irq, // request to core, normal
	output logic fast_irq // request to core, fast
);
	import vipn_pkg::*;

	vipn_apb_req_t req;
	logic [31:0] priority_sys_timers;
	logic [31:0] priority_serial_ext;
	logic [31:0] priority_pwm_logic_ext;
	logic [1:0] nesting_control;
	logic [vipn_base_w-1:0] vector_base;
	logic [nsrc-1:0] normal_enable_mask;
	logic [nsrc-1:0] fast_enable_mask;
	logic [31:0] next_p0, next_p1, next_p2;
	logic [1:0] next_nest;
	logic [vipn_base_w-1:0] next_base;
	logic [nsrc-1:0] next_nen, next_fen;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic next_nirq, next_firq;
	logic [7:0] normal_in_service_stack, fast_in_service_stack;
	logic [3*nsrc-1:0] lvls;
	logic normal_nest_enable, fast_nest_enable;
	logic [nsrc-1:0] normal_active, fast_active;
	vipn_pick_t npick, fpick;
	logic n_push, f_push, n_pop, f_pop;
	logic wr_hit, rd_hit, known;

	// is this address one of ours
	function automatic logic is_mapped(input logic [31:0] a);
		case (a)
			vipn_a_prio0, vipn_a_prio1, vipn_a_prio2, vipn_a_nest,
			vipn_a_nstk, vipn_a_fstk, vipn_a_base, vipn_a_nvec,
			vipn_a_fvec, vipn_a_nen, vipn_a_fen: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction : is_mapped

	// vector word: base above, source number below
	function automatic logic [31:0] vec_word(input logic [4:0] s,
		input logic [vipn_base_w-1:0] b);
		vec_word = '0;
		vec_word[vipn_vec_base_lsb +: vipn_base_w] = b; // RQ16
		vec_word[vipn_vec_src_lsb +: 5] = s; // RQ16
	endfunction : vec_word

	assign req = '{sel: psel, enable: penable, write: pwrite,
		addr: paddr, wdata: pwdata};
	assign known = is_mapped(req.addr);
	// access phase completes in the first access cycle
	assign wr_hit = req.sel && req.enable && req.write && known;
	assign rd_hit = req.sel && req.enable && !req.write && known;
	assign normal_nest_enable = nesting_control[vipn_nest_norm_bit]; // RQ8
	assign fast_nest_enable = nesting_control[vipn_nest_fast_bit]; // RQ9

	// level table in source order, source 0 held at zero
	assign lvls[2:0] = 3'h0; // RQ3
	assign lvls[3*1 +: 3] = priority_sys_timers[6:4]; // RQ3
	assign lvls[3*2 +: 3] = priority_sys_timers[10:8]; // RQ2
	assign lvls[3*3 +: 3] = priority_sys_timers[14:12]; // RQ2
	assign lvls[3*4 +: 3] = priority_sys_timers[18:16]; // RQ2
	assign lvls[3*5 +: 3] = priority_sys_timers[22:20]; // RQ1
	assign lvls[3*6 +: 3] = priority_sys_timers[26:24]; // RQ1
	assign lvls[3*7 +: 3] = priority_sys_timers[30:28]; // RQ1
	assign lvls[3*8 +: 3] = priority_serial_ext[2:0]; // RQ5
	assign lvls[3*9 +: 3] = priority_serial_ext[6:4]; // RQ5
	assign lvls[3*10 +: 3] = priority_serial_ext[10:8]; // RQ5
	assign lvls[3*11 +: 3] = priority_serial_ext[14:12]; // RQ5
	assign lvls[3*12 +: 3] = priority_serial_ext[18:16]; // RQ5
	assign lvls[3*13 +: 3] = priority_serial_ext[22:20]; // RQ4
	assign lvls[3*14 +: 3] = priority_serial_ext[26:24]; // RQ4
	assign lvls[3*15 +: 3] = priority_serial_ext[30:28]; // RQ4
	assign lvls[3*16 +: 3] = priority_pwm_logic_ext[2:0]; // RQ7
	assign lvls[3*17 +: 3] = priority_pwm_logic_ext[6:4]; // RQ7
	assign lvls[3*18 +: 3] = priority_pwm_logic_ext[10:8]; // RQ7
	assign lvls[3*19 +: 3] = priority_pwm_logic_ext[14:12]; // RQ6
	assign lvls[3*20 +: 3] = priority_pwm_logic_ext[18:16]; // RQ6
	assign lvls[3*21 +: 3] = priority_pwm_logic_ext[22:20]; // RQ6

	// active status per path
	assign normal_active = normal_raw_request & normal_enable_mask; // RQ17
	assign fast_active = fast_raw_request & fast_enable_mask; // RQ17

	// stacks are pushed by vector reads only while nesting is on
	assign n_push = rd_hit && req.addr == vipn_a_nvec &&
		normal_nest_enable && npick.found; // RQ12
	assign f_push = rd_hit && req.addr == vipn_a_fvec &&
		fast_nest_enable && fpick.found; // RQ18
	assign n_pop = wr_hit && req.addr == vipn_a_nstk; // RQ14
	assign f_pop = wr_hit && req.addr == vipn_a_fstk; // RQ18

	vipn_pick #(.nsrc(nsrc)) u_npick (
		.active(normal_active),
		.lvls(lvls),
		.use_prio(normal_nest_enable),
		.stack(normal_in_service_stack),
		.pick(npick)
	);

	vipn_pick #(.nsrc(nsrc)) u_fpick (
		.active(fast_active),
		.lvls(lvls),
		.use_prio(fast_nest_enable),
		.stack(fast_in_service_stack),
		.pick(fpick)
	);

	vipn_stack #(.levels(vipn_lvls)) u_nstack (
		.pclk(pclk),
		.presetn(presetn),
		.push(n_push),
		.push_lvl(npick.lvl),
		.pop(n_pop),
		.stack(normal_in_service_stack)
	);

	vipn_stack #(.levels(vipn_lvls)) u_fstack (
		.pclk(pclk),
		.presetn(presetn),
		.push(f_push),
		.push_lvl(fpick.lvl),
		.pop(f_pop),
		.stack(fast_in_service_stack)
	);

	// register writes, reserved bits masked off
	always_comb begin
		next_p0 = priority_sys_timers;
		next_p1 = priority_serial_ext;
		next_p2 = priority_pwm_logic_ext;
		next_nest = nesting_control;
		next_base = vector_base;
		next_nen = normal_enable_mask;
		next_fen = fast_enable_mask;
		if (wr_hit) begin
			case (req.addr)
				vipn_a_prio0: next_p0 = req.wdata & vipn_m_prio0; // RQ1
				vipn_a_prio1: next_p1 = req.wdata & vipn_m_prio1; // RQ4
				vipn_a_prio2: next_p2 = req.wdata & vipn_m_prio2; // RQ6
				vipn_a_nest: next_nest = req.wdata[1:0]; // RQ8 RQ9
				vipn_a_base: next_base = req.wdata[vipn_base_w-1:0];
				vipn_a_nen: next_nen = req.wdata[nsrc-1:0];
				vipn_a_fen: next_fen = req.wdata[nsrc-1:0];
				default: ;
			endcase
		end
	end

	// read mux, answer and core requests
	always_comb begin
		next_prdata = prdata;
		next_pready = req.sel && !req.enable;
		next_pslverr = req.sel && !req.enable && !is_mapped(req.addr);
		if (req.sel && !req.enable && !req.write) begin
			case (req.addr)
				vipn_a_prio0: next_prdata = priority_sys_timers;
				vipn_a_prio1: next_prdata = priority_serial_ext;
				vipn_a_prio2: next_prdata = priority_pwm_logic_ext;
				vipn_a_nest: next_prdata = {30'h0, nesting_control};
				vipn_a_nstk: next_prdata = {24'h0, normal_in_service_stack};
				vipn_a_fstk: next_prdata = {24'h0, fast_in_service_stack};
				vipn_a_base: next_prdata = {16'h0, vector_base};
				vipn_a_nvec: next_prdata = vec_word(npick.src,
					vector_base); // RQ16
				vipn_a_fvec: next_prdata = vec_word(fpick.src,
					vector_base);
				vipn_a_nen: next_prdata = {10'h0, normal_enable_mask};
				vipn_a_fen: next_prdata = {10'h0, fast_enable_mask};
				default: next_prdata = vipn_rst_word;
			endcase
		end
		next_firq = fpick.found; // RQ20 RQ11
		next_nirq = npick.found && !fpick.found; // RQ11 RQ20
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			priority_sys_timers <= vipn_rst_word;
			priority_serial_ext <= vipn_rst_word;
			priority_pwm_logic_ext <= vipn_rst_word;
			nesting_control <= '0;
			vector_base <= '0;
			normal_enable_mask <= '0;
			fast_enable_mask <= '0;
			prdata <= vipn_rst_word;
			pready <= 1'b0;
			pslverr <= 1'b0;
			normal_irq <= 1'b0;
			fast_irq <= 1'b0;
		end else begin
			priority_sys_timers <= next_p0;
			priority_serial_ext <= next_p1;
			priority_pwm_logic_ext <= next_p2;
			nesting_control <= next_nest;
			vector_base <= next_base;
			normal_enable_mask <= next_nen;
			fast_enable_mask <= next_fen;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			normal_irq <= next_nirq;
			fast_irq <= next_firq;
		end
	end
endmodule : vipn_top

// >>> dv/test_vipn_top.sv
/* self-checking bench for the priority and nesting block.
   assumes apb answers with pready; source model on the far side. */
`timescale 1ns/1ns
module test_vipn_top;
	import vipn_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, normal_irq, fast_irq, err;
	logic [21:0] nwant = '0;
	logic [21:0] fwant = '0;
	logic [21:0] nraw, fraw;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [31:0] ra [6] = '{vipn_a_prio0, vipn_a_prio1, vipn_a_prio2,
		vipn_a_nest, vipn_a_nstk, vipn_a_fstk};
	logic [31:0] rm [3] = '{vipn_m_prio0, vipn_m_prio1, vipn_m_prio2};
	// 100 mhz clock
	always #5 pclk = ~pclk;
	vipn_sources i_src (.pclk, .presetn, .normal_want(nwant),
		.fast_want(fwant), .normal_raw(nraw), .fast_raw(fraw));
	vipn_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .normal_raw_request(nraw),
		.fast_raw_request(fraw), .normal_irq, .fast_irq);
	task automatic check(input string s, input logic [31:0] seen, x);
		n_compared++;
		if (seen !== x) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", s, x, seen);
		end
	endtask : check
	task automatic xfer(input logic w, input logic [31:0] a, d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [31:0] a, d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rchk(input logic [31:0] a, x, input string s);
		xfer(1'b0, a, 32'h0);
		check(s, rd, x);
	endtask : rchk
	// request lines settle one cycle after the sources
	task automatic irq(input logic [31:0] x);
		repeat (3) @(posedge pclk);
		check("irq lines", {30'h0, fast_irq, normal_irq}, x);
	endtask : irq
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	// cuts a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			bad_count++;
			finish_test();
		end
	end
	// main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rchk(ra[i], vipn_rst_word, "reset value");
		for (int i = 0; i < 3; i++) begin
			wr(ra[i], 32'hffff_ffff);
			rchk(ra[i], rm[i], "fields");
			wr(ra[i], 32'h0);
		end
		wr(vipn_a_nest, 32'h0000_0003);
		rchk(vipn_a_nest, 32'h0000_0003, "nesting");
		check("no error", {31'h0, err}, 32'h0);
		xfer(1'b1, 32'hffff_0040, 32'h0000_0001);
		check("unmapped", {31'h0, err}, 32'h1);
		rchk(32'hffff_0040, 32'h0, "unmapped read");
		check("unmapped read error", {31'h0, err}, 32'h1);
		$display("test registers finished");
		wr(vipn_a_nest, 32'h0);
		wr(vipn_a_base, 32'h0000_1234);
		wr(vipn_a_nen, 32'h0000_0018);
		wr(vipn_a_fen, 32'h0000_0010);
		rchk(vipn_a_base, 32'h0000_1234, "base");
		rchk(vipn_a_nen, 32'h0000_0018, "normal mask");
		rchk(vipn_a_fen, 32'h0000_0010, "fast mask");
		nwant <= 22'h00_0020;
		irq(32'h0);
		nwant <= 22'h00_0018;
		fwant <= 22'h00_0010;
		irq(32'h2);
		fwant <= '0;
		irq(32'h1);
		wr(vipn_a_prio0, 32'h0000_7000);
		rchk(vipn_a_nvec, 32'h0009_1a0c, "flat vector");
		rchk(vipn_a_nstk, 32'h0, "no push");
		$display("test flat finished");
		wr(vipn_a_nest, 32'h1);
		wr(vipn_a_prio0, 32'h0003_5000);
		irq(32'h1);
		rchk(vipn_a_nvec, 32'h0009_1a10, "vector");
		rchk(vipn_a_nstk, 32'h8, "push");
		irq(32'h0);
		wr(vipn_a_prio0, 32'h0003_0000);
		irq(32'h1);
		rchk(vipn_a_nvec, 32'h0009_1a0c, "outrank");
		rchk(vipn_a_nstk, 32'h9, "second push");
		wr(vipn_a_nstk, 32'hff);
		rchk(vipn_a_nstk, 32'h8, "first pop");
		wr(vipn_a_nstk, 32'hff);
		rchk(vipn_a_nstk, 32'h0, "second pop");
		wr(vipn_a_prio0, 32'h0);
		rchk(vipn_a_nvec, 32'h0009_1a0c, "tie");
		rchk(vipn_a_nstk, 32'h1, "tie push");
		wr(vipn_a_nstk, 32'hff);
		$display("test nesting finished");
		wr(vipn_a_nest, 32'h3);
		fwant <= 22'h00_0010;
		irq(32'h2);
		rchk(vipn_a_fvec, 32'h0009_1a10, "fast vector");
		rchk(vipn_a_fstk, 32'h1, "fast push");
		irq(32'h1);
		wr(vipn_a_fstk, 32'hff);
		rchk(vipn_a_fstk, 32'h0, "fast pop");
		irq(32'h2);
		$display("test fast finished");
		finish_test();
	end
endmodule : test_vipn_top

// >>> dv/vipn_sources.sv
/* peripheral sources beside the block: request levels per source.
   assumes the bench names the sources that want service. */
`timescale 1ns/1ns
module vipn_sources #(
	parameter int unsigned nsrc = 22
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic [nsrc-1:0] normal_want, // normal wanted
	input wire logic [nsrc-1:0] fast_want, // fast wanted
	output logic [nsrc-1:0] normal_raw, // normal levels
	output logic [nsrc-1:0] fast_raw // fast levels
);
	// levels move just after an edge and follow the wanted inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			normal_raw <= '0;
			fast_raw <= '0;
		end else begin
			normal_raw <= normal_want;
			fast_raw <= fast_want;
		end
	end
endmodule : vipn_sources

// >>> dv/vipn_top_assertions.sv
/* checker on the ports of the priority and nesting block.
   assumes one-cycle apb access and registered request lines. */
`timescale 1ns/1ns
module vipn_top_assertions
	import vipn_pkg::*;
#(
	parameter int unsigned nsrc = vipn_nsrc
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic psel, // select
	input wire logic penable, // access
	input wire logic pwrite, // direction
	input wire logic [31:0] paddr, // address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic [nsrc-1:0] normal_raw_request, // normal
	input wire logic [nsrc-1:0] fast_raw_request, // fast
	input wire logic normal_irq, // normal request
	input wire logic fast_irq // fast request
);
	logic wr, rd;
	logic [31:0] sh0, sh1, shn, shb;
	// completed transfers
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	// shadow of what software wrote
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{sh0, sh1, shn, shb} <= '0;
		end else if (wr) begin
			case (paddr)
				vipn_a_prio0: sh0 <= pwdata;
				vipn_a_prio1: sh1 <= pwdata;
				vipn_a_nest: shn <= pwdata;
				vipn_a_base: shb <= pwdata;
				default: ;
			endcase
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	prio0_read_a:
		assert property (rd && paddr == vipn_a_prio0
		|-> prdata == (sh0 & vipn_m_prio0)) else $error("prio0 read");
	prio1_read_a:
		assert property (rd && paddr == vipn_a_prio1
		|-> prdata == (sh1 & vipn_m_prio1)) else $error("prio1 read");
	nest_read_a:
		assert property (rd && paddr == vipn_a_nest
		|-> prdata == (shn & 32'h0000_0003)) else $error("nest read");
	vec_fields_a:
		assert property (rd && paddr == vipn_a_nvec |-> prdata[22:7]
		== shb[15:0] && prdata[6:2] < 5'd22 && prdata[31:23] == 9'h0)
		else $error("vector fields");
	fast_first_a:
		assert property (fast_irq |-> !normal_irq) else $error("both");
	irq_cause_a:
		assert property (normal_irq |-> $past(|normal_raw_request))
		else $error("irq without source");
	stk_block_a:
		assert property (rd && paddr == vipn_a_nvec && shn[0] && normal_irq
		&& $stable(normal_raw_request) ##1 $stable(normal_raw_request)[*2]
		|-> !normal_irq) else $error("normal not blocked");
	fstk_block_a:
		assert property (rd && paddr == vipn_a_fvec && shn[1] && fast_irq
		&& $stable(fast_raw_request) ##1 $stable(fast_raw_request)[*2]
		|-> !fast_irq) else $error("fast not blocked");
	cover property (rd && paddr == vipn_a_nvec && normal_irq);
	cover property (wr && paddr == vipn_a_nstk);
	cover property (fast_irq && |normal_raw_request);
endmodule : vipn_top_assertions
bind vipn_top vipn_top_assertions #(.nsrc(nsrc)) i_chk (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.normal_raw_request, .fast_raw_request, .normal_irq, .fast_irq);

// >>> pkg/vipn_pkg.sv
/*
 * constants, register map and carrier types for the priority and nesting
 * section of a vectored interrupt controller.
 * assumes an apb slave at 100 mhz and 22 normal plus 22 fast sources.
 */
// Function
// RQ1 - pll, converter, flash levels in first register
// RQ2 - timer 2, 1, 0 levels in first register
// RQ3 - soft level bits 6:4; source 0 unprioritized
// RQ4 - supply, comparator, ext0 levels in second register
// RQ5 - spi and i2c levels in second register
// RQ6 - pwm, logic1, ext3 levels; top bits reserved
// RQ7 - ext2, logic0, ext1 levels in third register
// RQ8 - control bit 0 enables normal nesting, priority
// RQ9 - control bit 1 enables fast nesting, priority
// RQ10 - nesting off: deliver, no nesting, ignore levels
// RQ11 - non-nesting: fast beats normal
// RQ12 - vector read sets stack bit at priority
// RQ13 - set stack bit blocks equal, lower priorities
// RQ14 - each stack write clears lowest set bit
// RQ15 - software leaves reserved upper bits alone
// RQ16 - vector gives source number and base
// RQ17 - active equals raw request and enable mask
// RQ18 - fast path has its own stack
// RQ19 - ties go to lowest source number
// RQ20 - request only when outranking every stack bit
package vipn_pkg;
	localparam int unsigned vipn_nsrc = 22;
	localparam int unsigned vipn_lvls = 8;
	localparam logic [31:0] vipn_rst_word = 32'h0000_0000;
	// byte addresses of the registers
	localparam logic [31:0] vipn_a_prio0 = 32'hffff_0020;
	localparam logic [31:0] vipn_a_prio1 = 32'hffff_0024;
	localparam logic [31:0] vipn_a_prio2 = 32'hffff_0028;
	localparam logic [31:0] vipn_a_nest = 32'hffff_0030;
	localparam logic [31:0] vipn_a_nstk = 32'hffff_003c;
	localparam logic [31:0] vipn_a_fstk = 32'hffff_013c;
	localparam logic [31:0] vipn_a_base = 32'hffff_0014;
	localparam logic [31:0] vipn_a_nvec = 32'hffff_001c;
	localparam logic [31:0] vipn_a_fvec = 32'hffff_011c;
	localparam logic [31:0] vipn_a_nen = 32'hffff_0200;
	localparam logic [31:0] vipn_a_fen = 32'hffff_0204;
	// writable masks; reserved bits read zero
	localparam logic [31:0] vipn_m_prio0 = 32'h7777_7770;
	localparam logic [31:0] vipn_m_prio1 = 32'h7777_7777;
	localparam logic [31:0] vipn_m_prio2 = 32'h0077_7777;
	localparam logic [31:0] vipn_m_src = 32'h003f_ffff;
	localparam int unsigned vipn_nest_norm_bit = 0;
	localparam int unsigned vipn_nest_fast_bit = 1;
	localparam int unsigned vipn_base_w = 16;
	localparam int unsigned vipn_vec_src_lsb = 2;
	localparam int unsigned vipn_vec_base_lsb = 7;
	// apb request as one bundle
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} vipn_apb_req_t;
	// outcome of a priority search
	typedef struct packed {
		logic found;
		logic [4:0] src;
		logic [2:0] lvl;
	} vipn_pick_t;
endpackage : vipn_pkg
